// ---- hdl/iass_pkg.sv ----
/*
  Shared constants and types of the interleaved converter sample sequencer.
  Assumes a single 40 MHz system clock that also serves as conversion clock.
*/
`default_nettype none

package iass_pkg;
  localparam int CLK_PERIOD_NS    = 25;
  localparam int CONV_TIME_NS     = 400;
  localparam int CONV_CLK_NOM_MHZ = 50;
  // conversion length in conversion clocks, fixed by the nominal figure
  localparam int CONV_CYCLES      = (CONV_TIME_NS * CONV_CLK_NOM_MHZ + 999) / 1000;
  localparam int CNT_W            = $clog2(CONV_CYCLES + 1);
  localparam int DATA_W_DEF       = 12;
  localparam int BUF_DEPTH        = 2;
  localparam logic PHASE_RST      = 1'b0;
  localparam logic CORE_ODD       = 1'b0;
  localparam logic CORE_EVEN      = 1'b1;

  typedef enum logic [1:0] {
    IASS_IDLE = 2'b01,
    IASS_RUN  = 2'b10
  } iass_state_t;
endpackage : iass_pkg

`default_nettype wire

// ---- hdl/iass_stream_if.sv ----
/*
  Result stream carrier between the sequencer and its two-entry buffer.
  Assumes both ends run on the same clock.
*/
`default_nettype none

interface iass_stream_if #(
  parameter int W = 12
) ();
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  logic         core;

  modport src (output valid, output data, output core, input ready);
  modport snk (input valid, input data, input core, output ready);
endinterface : iass_stream_if

`default_nettype wire

// ---- hdl/iass_skid_buf.sv ----
/*
  Two-entry buffer with registered outputs on the draining side.
  Assumes sink and source share clk; ready toward the source is registered state.
*/
`default_nettype none

module iass_skid_buf #(
  parameter int W     = iass_pkg::DATA_W_DEF,
  parameter int DEPTH = iass_pkg::BUF_DEPTH
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  iass_stream_if.snk      in_s,
  iass_stream_if.src      out_s
);
  if (DEPTH != 2) begin : g_chk
    $error("iass_skid_buf supports a depth of two only");
  end

  typedef struct packed {
    logic         hv;
    logic [W-1:0] hd;
    logic         hc;
    logic         sv;
    logic [W-1:0] sd;
    logic         sc;
  } iass_buf_st_t;

  iass_buf_st_t st_reg;
  iass_buf_st_t st_next;
  logic         pop;
  logic         push;

  assign in_s.ready  = !st_reg.sv;
  assign out_s.valid = st_reg.hv;
  assign out_s.data  = st_reg.hd;
  assign out_s.core  = st_reg.hc;
  assign pop         = st_reg.hv && out_s.ready;
  assign push        = in_s.valid && !st_reg.sv;

  always_comb begin
    st_next = st_reg;
    if (pop) begin
      st_next.hv = st_reg.sv;
      st_next.hd = st_reg.sd;
      st_next.hc = st_reg.sc;
      st_next.sv = 1'b0;
    end
    if (push) begin
      // spare only fills when the head is kept, so order is preserved
      if (!st_next.hv) begin
        st_next.hv = 1'b1;
        st_next.hd = in_s.data;
        st_next.hc = in_s.core;
      end else begin
        st_next.sv = 1'b1;
        st_next.sd = in_s.data;
        st_next.sc = in_s.core;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  property p_buf_hold;
    @(posedge clk) disable iff (sys_rst)
    (st_reg.hv && !out_s.ready) |=> (st_reg.hv && $stable(st_reg.hd) && $stable(st_reg.hc));
  endproperty
  a_buf_hold: assert property (p_buf_hold) else $error("buffer head changed while stalled");
endmodule // iass_skid_buf

`default_nettype wire

// ---- hdl/iass_sequencer.sv ----
/*
  Interleaved two-core sample sequencer: halves the 2fs sample rate into two
  opposite per-core sample clocks, times each conversion and merges results in order.
  Assumes sample_tick is a one-cycle 2fs enable, trig_in comes from a shared timer
  and out_* feeds a DMA engine; all inputs are synchronous to clk.
*/
// Notes on behaviour
// R1: the 2fs sample tick is divided by two so each per-core clock is high and low equally long.
// R2: the even-core clock is always the inverse of the odd-core clock, half a period apart.
// R3: each core samples only on the rising edge of its own sample clock.
// R4: the odd core yields the first result of each pair and the even core follows half a period later.
// R5: the merged stream alternates odd and even results at twice the per-core rate.
// R6: the odd-to-even sample offset is fixed at exactly half a per-core period with no drift.
// R7: both cores convert the same input in alternation and never sample at the same instant.
// R8: one outside timer gives a single common trigger that starts both cores in step.
// R9: an outside DMA engine moves every result into one buffer in the order produced.
// R10: each conversion takes a fixed number of conversion clocks, which bounds the trigger rate.
// R11: after reset or start the divider is in a known phase so the odd core gets the first rising edge.
`default_nettype none

module iass_sequencer #(
  parameter int DATA_W = iass_pkg::DATA_W_DEF
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              sample_tick,
  input  wire logic              trig_in,
  input  wire logic              stop_in,
  input  wire logic [DATA_W-1:0] ain_code,
  input  wire logic              ovr_clr,
  input  wire logic              out_ready,
  output logic                   odd_clk,
  output logic                   even_clk,
  output logic                   odd_smp,
  output logic                   even_smp,
  output logic                   running,
  output logic                   overrun,
  output logic                   out_valid,
  output logic [DATA_W-1:0]      out_data,
  output logic                   out_core
);
  if (DATA_W < 1 || DATA_W > 16) begin : g_chk
    $error("iass_sequencer data width must lie in 1..16");
  end

  localparam int CW = iass_pkg::CNT_W;
  localparam logic [CW-1:0] CONV_LOAD = CW'(iass_pkg::CONV_CYCLES);
  localparam int CONV_LAT = iass_pkg::CONV_CYCLES;

  typedef struct packed {
    iass_pkg::iass_state_t st;
    logic                  odd_clk;
    logic                  even_clk;
    logic                  odd_smp;
    logic                  even_smp;
    logic [CW-1:0]         ocnt;
    logic [CW-1:0]         ecnt;
    logic                  opend;
    logic                  epend;
    logic [DATA_W-1:0]     odat;
    logic [DATA_W-1:0]     edat;
    logic                  next_core;
    logic                  overrun;
  } iass_top_st_t;

  function automatic logic [CW-1:0] iass_dec(input logic [CW-1:0] c);
    iass_dec = (c != '0) ? c - CW'(1) : c;
  endfunction

  iass_top_st_t st_reg;
  iass_top_st_t st_next;
  logic         fire;
  logic         quiet;

  iass_stream_if #(.W(DATA_W)) bi ();
  iass_stream_if #(.W(DATA_W)) bo ();

  iass_skid_buf #(.W(DATA_W), .DEPTH(iass_pkg::BUF_DEPTH)) u_buf (
    .clk     (clk),
    .sys_rst (sys_rst),
    .in_s    (bi),
    .out_s   (bo)
  );

  // results enter the buffer in strict odd/even alternation, chosen by next_core
  assign bi.valid = (st_reg.next_core == iass_pkg::CORE_EVEN) ? st_reg.epend : st_reg.opend; // R5
  assign bi.data  = (st_reg.next_core == iass_pkg::CORE_EVEN) ? st_reg.edat : st_reg.odat;
  assign bi.core  = st_reg.next_core;
  assign fire     = bi.valid && bi.ready;
  assign bo.ready = out_ready;
  // a restart is refused until nothing is in flight, so the pairing cannot slip
  assign quiet    = (st_reg.ocnt == '0) && (st_reg.ecnt == '0) && !st_reg.opend && !st_reg.epend && !bo.valid;

  always_comb begin
    st_next          = st_reg;
    st_next.odd_smp  = 1'b0;
    st_next.even_smp = 1'b0;
    st_next.ocnt     = iass_dec(st_reg.ocnt); // R10
    st_next.ecnt     = iass_dec(st_reg.ecnt); // R10
    if (st_reg.ocnt == CW'(1)) begin
      st_next.opend = 1'b1;
    end
    if (st_reg.ecnt == CW'(1)) begin
      st_next.epend = 1'b1;
    end
    if (fire) begin
      if (st_reg.next_core == iass_pkg::CORE_EVEN) begin
        st_next.epend = 1'b0;
      end else begin
        st_next.opend = 1'b0;
      end
      st_next.next_core = !st_reg.next_core; // R5
    end
    if (ovr_clr) begin
      st_next.overrun = 1'b0;
    end
    unique case (st_reg.st)
      iass_pkg::IASS_IDLE: begin
        if (trig_in && quiet) begin // R8
          st_next.st        = iass_pkg::IASS_RUN;
          st_next.odd_clk   = iass_pkg::PHASE_RST; // R11
          st_next.even_clk  = !iass_pkg::PHASE_RST; // R2
          st_next.next_core = iass_pkg::CORE_ODD; // R4
        end
      end
      iass_pkg::IASS_RUN: begin
        if (stop_in) begin
          st_next.st = iass_pkg::IASS_IDLE;
        end else if (sample_tick) begin
          st_next.odd_clk  = !st_reg.odd_clk; // R1 R6
          st_next.even_clk = st_reg.odd_clk; // R2
          if (!st_reg.odd_clk) begin
            // odd clock rises: odd core samples unless still converting or pending (then overrun), even core never does here
            if (st_reg.ocnt != '0 || st_reg.opend) begin
              st_next.overrun = 1'b1;
            end else begin
              st_next.odd_smp = 1'b1; // R3
              st_next.ocnt    = CONV_LOAD; // R10
              st_next.odat    = ain_code; // R7
            end
          end else begin
            if (st_reg.ecnt != '0 || st_reg.epend) begin
              st_next.overrun = 1'b1;
            end else begin
              st_next.even_smp = 1'b1; // R3
              st_next.ecnt     = CONV_LOAD; // R10
              st_next.edat     = ain_code; // R7
            end
          end
        end
      end
      default: begin
        st_next.st = iass_pkg::IASS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg          <= '0;
      st_reg.st       <= iass_pkg::IASS_IDLE;
      st_reg.odd_clk  <= iass_pkg::PHASE_RST; // R11
      st_reg.even_clk <= !iass_pkg::PHASE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign odd_clk   = st_reg.odd_clk;
  assign even_clk  = st_reg.even_clk;
  assign odd_smp   = st_reg.odd_smp;
  assign even_smp  = st_reg.even_smp;
  assign running   = (st_reg.st == iass_pkg::IASS_RUN);
  assign overrun   = st_reg.overrun;
  assign out_valid = bo.valid;
  assign out_data  = bo.data;
  assign out_core  = bo.core;

  // helper state read only by the checks below
  logic start_acc;
  logic odd_seen;
  logic last_smp_odd;
  logic last_out_core;
  assign start_acc = (st_reg.st == iass_pkg::IASS_IDLE) && trig_in && quiet;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      odd_seen      <= 1'b0;
      last_smp_odd  <= 1'b0;
      last_out_core <= iass_pkg::CORE_EVEN;
    end else begin
      if (start_acc) begin
        odd_seen      <= 1'b0;
        last_out_core <= iass_pkg::CORE_EVEN;
      end else begin
        if (st_reg.odd_smp) begin
          odd_seen <= 1'b1;
        end
        if (bo.valid && out_ready) begin
          last_out_core <= bo.core;
        end
      end
      if (st_reg.odd_smp) begin
        last_smp_odd <= 1'b1;
      end else if (st_reg.even_smp) begin
        last_smp_odd <= 1'b0;
      end
    end
  end

  property p_div_half;
    @(posedge clk) disable iff (sys_rst)
    (running && !stop_in && sample_tick) |=> (odd_clk != $past(odd_clk));
  endproperty
  a_div_half: assert property (p_div_half) else $error("per-core clock did not toggle on tick"); // R1

  property p_no_tick;
    @(posedge clk) disable iff (sys_rst)
    (!sample_tick && !start_acc) |=> $stable(odd_clk);
  endproperty
  a_no_tick: assert property (p_no_tick) else $error("per-core clock moved without a tick"); // R1

  property p_inverse;
    @(posedge clk) disable iff (sys_rst)
    even_clk == !odd_clk;
  endproperty
  a_inverse: assert property (p_inverse) else $error("even clock is not the inverse of odd clock"); // R2

  property p_odd_edge;
    @(posedge clk) disable iff (sys_rst)
    odd_smp |-> $rose(odd_clk);
  endproperty
  a_odd_edge: assert property (p_odd_edge) else $error("odd sample off its rising edge"); // R3

  property p_even_edge;
    @(posedge clk) disable iff (sys_rst)
    even_smp |-> ($rose(even_clk) && !odd_smp);
  endproperty
  a_even_edge: assert property (p_even_edge) else $error("even sample off its rising edge"); // R7

  property p_odd_first;
    @(posedge clk) disable iff (sys_rst)
    even_smp |-> odd_seen;
  endproperty
  a_odd_first: assert property (p_odd_first) else $error("even core sampled before odd core"); // R4

  property p_order;
    @(posedge clk) disable iff (sys_rst)
    even_smp |-> last_smp_odd;
  endproperty
  a_order: assert property (p_order) else $error("even sample not preceded by odd sample"); // R4

  property p_alt;
    @(posedge clk) disable iff (sys_rst)
    (out_valid && out_ready) |-> (out_core != last_out_core);
  endproperty
  a_alt: assert property (p_alt) else $error("merged stream did not alternate cores"); // R5

  property p_conv;
    @(posedge clk) disable iff (sys_rst)
    odd_smp |-> ##[CONV_LAT:CONV_LAT] $rose(st_reg.opend);
  endproperty
  a_conv: assert property (p_conv) else $error("odd conversion time wrong"); // R10

  c_start:   cover property (@(posedge clk) disable iff (sys_rst) start_acc ##1 running);
  c_pair:    cover property (@(posedge clk) disable iff (sys_rst) odd_smp ##[1:8] even_smp);
  c_stall:   cover property (@(posedge clk) disable iff (sys_rst) (out_valid && !out_ready) ##1 out_valid);
  c_overrun: cover property (@(posedge clk) disable iff (sys_rst) $rose(overrun));
endmodule // iass_sequencer

`default_nettype wire

// ---- sim/iass_far_side.sv ----
/*
  Far side of the sequencer: the shared sample timer and the DMA sink.
  Assumes clk is the system clock; the bench sets gap, stall and flush at falling edges.
*/
`default_nettype none

module iass_far_side #(
  parameter int W = iass_pkg::DATA_W_DEF
) (
  input  wire logic         clk,
  input  wire logic         running,
  input  wire logic         out_valid,
  input  wire logic [W-1:0] out_data,
  input  wire logic         out_core,
  input  wire logic [15:0]  gap,
  input  wire logic         stall,
  input  wire logic         flush,
  output logic              sample_tick,
  output logic [W-1:0]      ain_code,
  output logic              out_ready,
  output logic [15:0]       words,
  output logic [15:0]       bad
);
  logic [W-1:0] q[$];
  logic [W-1:0] held;
  logic [W-1:0] nxt;
  logic [15:0]  cnt;
  logic         stalled;

  initial begin
    sample_tick = 1'b0;
    ain_code    = '0;
    out_ready   = 1'b1;
    words       = '0;
    bad         = '0;
    cnt         = '0;
    held        = '0;
    stalled     = 1'b0;
  end

  // one timer feeds both cores, so their sample instants cannot drift apart
  always @(negedge clk) begin
    out_ready   <= !stall;
    sample_tick <= 1'b0;
    cnt         <= (gap == 16'h0 || cnt == gap - 16'h1) ? 16'h0 : cnt + 16'h1;
    if (gap != 16'h0 && cnt == gap - 16'h1) begin
      nxt = W'(ain_code + W'(16'h0A53));
      sample_tick <= 1'b1;
      ain_code    <= nxt;
      if (running && !flush) q.push_back(nxt);
    end
    if (flush) begin
      q.delete();
      words <= '0;
    end
  end

  // words arrive in sample order, odd core first, and hold while stalled
  always @(posedge clk) begin
    if (stalled && (!out_valid || out_data !== held)) bad <= bad + 16'h1;
    stalled <= out_valid && !out_ready;
    held    <= out_data;
    if (out_valid && out_ready && !flush) begin
      if (q.size() == 0 || out_data !== q[0] || out_core !== words[0]) bad <= bad + 16'h1;
      if (q.size() != 0) void'(q.pop_front());
      words <= words + 16'h1;
    end
  end
endmodule // iass_far_side

`default_nettype wire

// ---- sim/iass_sequencer_tb_top.sv ----
/*
  Self-checking bench of the interleaved sample sequencer.
  Assumes the far-side model drives tick, code and ready; the bench drives control pins.
*/
`default_nettype none

module iass_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk, sys_rst, trig_in, stop_in, ovr_clr, stall, flush;
  logic        sample_tick, out_ready, odd_clk, even_clk, odd_smp, even_smp;
  logic        running, overrun, out_valid, out_core, odd_prev;
  logic [11:0] ain_code, out_data;
  logic [15:0] gap, words, bad;
  int          err_total, checks_done, cyc, last_smp;

  iass_sequencer i_dut (.clk(clk), .sys_rst(sys_rst), .sample_tick(sample_tick), .trig_in(trig_in),
    .stop_in(stop_in), .ain_code(ain_code), .ovr_clr(ovr_clr), .out_ready(out_ready), .odd_clk(odd_clk),
    .even_clk(even_clk), .odd_smp(odd_smp), .even_smp(even_smp), .running(running), .overrun(overrun),
    .out_valid(out_valid), .out_data(out_data), .out_core(out_core));

  iass_far_side i_far (.clk(clk), .running(running), .out_valid(out_valid), .out_data(out_data),
    .out_core(out_core), .gap(gap), .stall(stall), .flush(flush), .sample_tick(sample_tick),
    .ain_code(ain_code), .out_ready(out_ready), .words(words), .bad(bad));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t value %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // clock shape checked every cycle of a run
  always @(posedge clk) begin
    cyc++;
    if (!sys_rst && running) begin
      check(even_clk, !odd_clk);
      check(odd_smp && even_smp, 1'b0);
      if (!overrun) begin
        check(odd_smp, odd_clk && !odd_prev);
      end else begin
        // a skipped sample raises the clock without a strobe, so only a strobe off the edge is wrong
        check(odd_smp && !(odd_clk && !odd_prev), 1'b0);
      end
    end
    odd_prev = odd_clk;
  end

  // waits for the next sample strobe; exp_gap 0 skips the spacing compare
  task automatic wait_smp(input logic exp_core, input int exp_gap);
    int n = 0;
    @(negedge clk);
    while (!odd_smp && !even_smp && n < 200) begin
      @(negedge clk);
      n++;
    end
    check(odd_smp || even_smp, 1'b1);
    check(even_smp, exp_core);
    if (exp_gap > 0) check(16'(cyc - last_smp), 16'(exp_gap));
    last_smp = cyc;
  endtask

  task automatic t_reset();
    check(odd_clk, 1'b0);
    check(even_clk, 1'b1);
    check({running, out_valid, overrun}, 3'h0);
  endtask

  task automatic t_stream();
    int t0;
    trig_in = 1'b1;
    gap     <= 16'h0019;
    @(negedge clk);
    trig_in = 1'b0;
    check(running, 1'b1);
    wait_smp(1'b0, 0);
    t0 = cyc;
    // a second start while running must not re-phase the divider
    trig_in = 1'b1;
    @(negedge clk);
    trig_in = 1'b0;
    while (!out_valid && cyc - t0 < 100) @(negedge clk);
    check(16'(cyc - t0), 16'h0015);
    for (int i = 0; i < 7; i++) wait_smp(!i[0], 25);
    gap <= '0;
    repeat (40) @(negedge clk);
    check(words, 16'h0008);
    check(bad, 16'h0000);
  endtask

  task automatic t_stall();
    stall <= 1'b1;
    gap   <= 16'h0019;
    for (int i = 0; i < 4; i++) wait_smp(i[0], (i == 0) ? 0 : 25);
    gap <= '0;
    repeat (30) @(negedge clk);
    check({out_valid, out_core, overrun}, 3'h4);
    stall <= 1'b0;
    repeat (30) @(negedge clk);
    check(words, 16'h000C);
    check(bad, 16'h0000);
  endtask

  task automatic t_overrun();
    stop_in = 1'b1;
    @(negedge clk);
    stop_in = 1'b0;
    check(running, 1'b0);
    repeat (30) @(negedge clk);
    // skipped samples break the data order, so the sink stops judging
    flush   <= 1'b1;
    trig_in = 1'b1;
    gap     <= 16'h0002;
    @(negedge clk);
    trig_in = 1'b0;
    repeat (12) @(negedge clk);
    check(overrun, 1'b1);
    gap <= '0;
    repeat (4) @(negedge clk);
    ovr_clr = 1'b1;
    @(negedge clk);
    ovr_clr = 1'b0;
    @(negedge clk);
    check(overrun, 1'b0);
  endtask

  initial begin
    // model controls change by non-blocking assignment, so the model reads them one edge late, without a race
    {sys_rst, trig_in, stop_in, ovr_clr} = 4'h8;
    {stall, flush} <= 2'h0;
    gap      <= '0;
    odd_prev = 1'b0;
    repeat (10) @(negedge clk);
    sys_rst = 1'b0;
    t_reset();
    t_stream();
    t_stall();
    t_overrun();
    complete_run();
  end

  initial begin
    repeat (6000) @(posedge clk);
    err_total++;
    complete_run();
  end
endmodule // iass_sequencer_tb_top

`default_nettype wire
